// ### tb/qdci_i2c_master.sv
// Bus master on the serial link; drives its own clock inside frames and for the one reset pulse
module qdci_i2c_master (
    input wire logic link_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // Half bit in link cycles: 40 gives about 390 kHz, 157 about 100 kHz
    int half = 40;

    // Idle: clock high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge link_clk);
    endtask

    // One bit; data moves mid low phase so the fall keeps its hold time
    task automatic put(input logic b, output logic r);
        tick(half / 2);
        sda_oe <= !b;
        tick(half - half / 2);
        scl <= 1'b1;
        tick(half);
        r = sda;
        scl <= 1'b0;
    endtask

    // Start or repeated start: data falls while the clock is high
    task automatic start();
        tick(half / 2);
        sda_oe <= 1'b0;
        tick(half / 2);
        scl <= 1'b1;
        tick(half);
        sda_oe <= 1'b1;
        tick(half);
        scl <= 1'b0;
    endtask

    // Stop: data rises while the clock is high, then the bus idles
    task automatic stop();
        tick(half / 2);
        sda_oe <= 1'b1;
        tick(half / 2);
        scl <= 1'b1;
        tick(half);
        sda_oe <= 1'b0;
        tick(half);
    endtask

    // One clock fall with data high, used while reset is held
    task automatic pulse();
        tick(2);
        scl <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(2);
    endtask

    // Eight bits MSB first, then the acknowledge slot
    task automatic xbyte(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
                         output logic ar);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put(tx[i], r);
            rx[i] = r;
        end
        put(ab, ar);
    endtask
endmodule

// ### tb/tb_quad_dac_command_interface.sv
module tb_quad_dac_command_interface;
    timeunit 1ns;
    timeprecision 1ps;
    import qdci_pkg::*;

    localparam logic [7:0] ADDR_W = {ADDR_FIXED, 2'b10, 1'b0};
    localparam logic [7:0] ADDR_R = {ADDR_FIXED, 2'b10, 1'b1};

    logic ref_clk;
    logic link_clk;
    logic resetn = 1'b0;
    logic pin_hi = 1'b1;
    logic pin_lo = 1'b0;
    logic load_n = 1'b1;
    logic scl;
    logic m_oe;
    logic sda_line;
    logic sda_out;
    logic sda_oe;
    qdci_chan_t [3:0] chan;
    logic [3:0] load_mask;
    logic ref_enable;
    int err_count = 0;
    int comparisons = 0;
    logic [9:0] e_in [4];
    logic [9:0] e_dac [4];
    logic [1:0] e_pw [4];
    logic [3:0] e_lm;
    logic e_ref;
    logic [7:0] rx;
    logic ar;

    // Two unrelated clocks; the link one only paces the master
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #16 link_clk = ~link_clk;
    end

    // Wired-AND data line with pull-up
    assign sda_line = !(m_oe | (sda_oe & !sda_out));

    qdci_core u_qdci_core (.ref_clk(ref_clk), .resetn(resetn), .link_scl(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .addr_pin_hi(pin_hi),
        .addr_pin_lo(pin_lo), .load_strobe_n(load_n), .chan(chan),
        .load_mask(load_mask), .ref_enable(ref_enable));
    qdci_i2c_master u_master (.link_clk(link_clk), .sda(sda_line), .scl(scl), .sda_oe(m_oe));

    task chk(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task exp_reset();
        for (int i = 0; i < 4; i++) begin
            e_in[i] = CODE_RESET;
            e_dac[i] = CODE_RESET;
            e_pw[i] = PWR_RESET;
        end
        e_lm = LDMASK_RESET;
        e_ref = REF_RESET;
    endtask

    // Expected effect of one complete word, with the load pin high
    task model(input logic [3:0] c, input logic [3:0] m, input logic [15:0] d);
        for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
                case (c)
                    CMD_WRITE: e_in[i] = d[CODE_LSB +: CODE_W];
                    CMD_WRUPD: begin
                        e_in[i] = d[CODE_LSB +: CODE_W];
                        e_dac[i] = d[CODE_LSB +: CODE_W];
                    end
                    CMD_UPDATE: e_dac[i] = e_in[i];
                    CMD_POWER: e_pw[i] = d[2 * i +: 2];
                    default: ;
                endcase
            end
        end
        if (c == CMD_LDMASK) e_lm = d[3:0];
        if (c == CMD_REFSET) e_ref = !d[REF_OFF_BIT];
        if (c == CMD_SWRST) exp_reset();
    endtask

    task chk_state();
        // Look between edges, once the outputs have settled
        @(negedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            chk(chan[i].input_code, e_in[i]);
            chk(chan[i].dac_code, e_dac[i]);
            chk(10'(chan[i].pwr_mode), 10'(e_pw[i]));
        end
        chk(10'(load_mask), 10'(e_lm));
        chk(10'(ref_enable), 10'(e_ref));
    endtask

    task wbyte(input logic [7:0] b, input logic nack);
        u_master.xbyte(b, 1'b1, rx, ar);
        chk(10'(ar), 10'(nack));
    endtask

    task word(input logic [3:0] c, input logic [3:0] m, input logic [15:0] d);
        wbyte({c, m}, 1'b0);
        wbyte(d[15:8], 1'b0);
        wbyte(d[7:0], 1'b0);
        model(c, m, d);
    endtask

    task wr(input logic [3:0] c, input logic [3:0] m, input logic [15:0] d);
        u_master.start();
        wbyte(ADDR_W, 1'b0);
        word(c, m, d);
        u_master.stop();
    endtask

    task t_reset();
        chk_state();
        chk(10'(sda_oe), 10'h000);
        $display("test reset done");
    endtask

    // Low six bits set to ones must not leak into the code
    task t_write();
        wr(CMD_WRITE, 4'hf, 16'h557f);
        chk_state();
        wr(CMD_WRUPD, 4'h5, 16'hffc0);
        chk_state();
        wr(CMD_UPDATE, 4'h2, 16'h0000);
        chk_state();
        $display("test write done");
    endtask

    // Nothing may change: no-op, reserved codes, short word, foreign addresses
    task t_refuse();
        logic [7:0] bad [3];
        bad = '{{ADDR_FIXED, 2'b01, 1'b0}, 8'h00, 8'hf4};
        u_master.start();
        wbyte(ADDR_W, 1'b0);
        word(CMD_NOP, 4'hf, 16'hffff);
        for (int c = 8; c < 16; c++) word(4'(c), 4'hf, 16'hffff);
        u_master.stop();
        chk_state();
        u_master.start();
        wbyte(ADDR_W, 1'b0);
        wbyte({CMD_WRITE, 4'hf}, 1'b0);
        wbyte(8'h12, 1'b0);
        u_master.stop();
        chk_state();
        for (int i = 0; i < 3; i++) begin
            u_master.start();
            wbyte(bad[i], 1'b1);
            wbyte({CMD_WRUPD, 4'hf}, 1'b1);
            u_master.stop();
        end
        chk_state();
        $display("test refuse done");
    endtask

    // Masked channels A and B ignore the pin; C and D turn transparent
    task t_load();
        wr(CMD_LDMASK, 4'h0, 16'h0003);
        wr(CMD_WRITE, 4'hf, 16'h8000);
        chk_state();
        @(posedge ref_clk);
        load_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        e_dac[2] = e_in[2];
        e_dac[3] = e_in[3];
        chk_state();
        @(posedge ref_clk);
        load_n <= 1'b1;
        repeat (10) @(posedge ref_clk);
        $display("test load done");
    endtask

    // First transfer at the slow rate
    task t_power();
        u_master.half = 157;
        wr(CMD_POWER, 4'hf, 16'h00e4);
        chk_state();
        u_master.half = 40;
        wr(CMD_POWER, 4'h1, 16'h00ff);
        chk_state();
        $display("test power done");
    endtask

    // Start at D, then wrap to A
    task t_read();
        logic [9:0] cd;
        wr(CMD_WRITE, 4'h1, 16'hc0c0);
        u_master.start();
        wbyte(ADDR_W, 1'b0);
        wbyte({CMD_NOP, 4'h8}, 1'b0);
        u_master.start();
        wbyte(ADDR_R, 1'b0);
        for (int i = 0; i < 4; i++) begin
            u_master.xbyte(8'hff, i == 3, rx, ar);
            cd = (i < 2) ? e_in[3] : e_in[0];
            chk(10'(rx), i[0] ? {2'h0, cd[1:0], 6'h00} : {2'h0, cd[9:2]});
        end
        u_master.stop();
        $display("test read done");
    endtask

    task t_ref();
        wr(CMD_REFSET, 4'h0, 16'h0001);
        chk_state();
        wr(CMD_SWRST, 4'h0, 16'h0000);
        chk_state();
        $display("test reference done");
    endtask

    task wrap_up();
        $display("err_count=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Reset spans a link clock fall so both domains see it
    initial begin
        exp_reset();
        fork
            u_master.pulse();
            repeat (10) @(posedge ref_clk);
        join
        resetn <= 1'b1;
        repeat (8) @(posedge ref_clk);
        t_reset();
        t_write();
        t_refuse();
        t_load();
        t_power();
        t_read();
        t_ref();
        wrap_up();
    end

    // Watchdog: tests need about 59000 cycles
    initial begin
        repeat (100000) @(posedge ref_clk);
        err_count++;
        wrap_up();
    end
endmodule

// ### verilog/qdci_core.sv
// Operation
// [RULE1] Each word is 24 bits, MSB first, clocked by the serial clock.
// [RULE2] First byte: upper nibble is the command, lower nibble the channel mask.
// [RULE3] Codes 0-7: nop, write, update, write+update, power, mask, reset, reference.
// [RULE4] Mask bit 16 selects channel A up to bit 19 for channel D.
// [RULE5] Channel code sits in bits 15..6; the six lowest bits are ignored.
// [RULE6] Bits are captured on falling serial clock edges, 24 per word.
// [RULE7] A command acts on every channel whose mask bit is set.
// [RULE8] Write loads input registers; low load pin makes unmasked ones transparent.
// [RULE9] Update copies input registers of selected channels into their DAC registers.
// [RULE10] Write+update loads DAC registers directly, regardless of the load pin.
// [RULE11] Channel code is straight binary, 0 to 1023.
// [RULE12] Reference is on after power-up and can be turned off by command.
// [RULE13] Serial slave works at both 100 kHz and 400 kHz.
// [RULE14] No 10-bit addressing and no answer to the general call.
// [RULE15] Reset puts every channel register into a known state.
// [RULE16] Address is 00011 followed by the two address pins.
// [RULE17] Command, high data, low data bytes follow; each is acknowledged.
// [RULE18] Readback returns input registers two bytes each, wrapping D to A.
// [RULE19] Power command takes two mode bits per channel from the low byte.
// [RULE20] A word cut short by a stop changes nothing.
// [RULE21] No-operation and reserved codes change nothing.
// [RULE22] Software reset restores channels, mask and reference to reset values.
module qdci_core #(
    parameter int PTR_W = 4
) (
    input logic ref_clk,
    input logic resetn,
    input logic link_scl,
    input logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input logic addr_pin_hi,
    input logic addr_pin_lo,
    input logic load_strobe_n,
    output qdci_pkg::qdci_chan_t [3:0] chan,
    output logic [3:0] load_mask,
    output logic ref_enable
);
    import qdci_pkg::*;

    localparam int DEPTH = 2 ** PTR_W;

    // Link side: bit ring and gray write pointer, on the serial clock
    logic [DEPTH-1:0] lbuf_q, lbuf_d;
    logic [PTR_W-1:0] wptr_q, wptr_d, wgray_q, wgray_d;

    // Each falling edge stores one line bit
    always_comb begin
        lbuf_d = lbuf_q;
        lbuf_d[wptr_q] = sda_in; // RULE6
        wptr_d = wptr_q + 1'b1;
        wgray_d = wptr_d ^ (wptr_d >> 1);
        if (!resetn) begin
            wptr_d = '0;
            wgray_d = '0;
        end
    end

    always_ff @(negedge link_scl) begin
        lbuf_q <= lbuf_d;
        wptr_q <= wptr_d;
        wgray_q <= wgray_d;
    end

    // Pin and pointer synchronisers; bus lines idle high
    logic [4:0] pin_m_q, pin_m_d, pin_s_q, pin_s_d;
    logic [1:0] line_p_q, line_p_d;
    logic [PTR_W-1:0] gray_m_q, gray_m_d, gray_s_q, gray_s_d;

    always_comb begin
        pin_m_d = {link_scl, sda_in, load_strobe_n, addr_pin_hi, addr_pin_lo};
        pin_s_d = pin_m_q;
        line_p_d = pin_s_q[4:3];
        gray_m_d = wgray_q;
        gray_s_d = gray_m_q;
        if (!resetn) begin
            pin_m_d = PIN_RESET;
            pin_s_d = PIN_RESET;
            line_p_d = 2'h3;
            gray_m_d = '0;
            gray_s_d = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        pin_m_q <= pin_m_d;
        pin_s_q <= pin_s_d;
        line_p_q <= line_p_d;
        gray_m_q <= gray_m_d;
        gray_s_q <= gray_s_d;
    end

    logic scl_s, sda_s, ld_n_s;
    logic start_ev, stop_ev;
    logic [PTR_W-1:0] wbin;

    // Gray pointer back to binary
    always_comb begin
        wbin[PTR_W-1] = gray_s_q[PTR_W-1];
        for (int i = PTR_W - 2; i >= 0; i--) begin
            wbin[i] = wbin[i+1] ^ gray_s_q[i];
        end
    end

    // Start and stop seen only while the clock stays high
    assign scl_s = pin_s_q[4];
    assign sda_s = pin_s_q[3];
    assign ld_n_s = pin_s_q[2];
    assign start_ev = scl_s && line_p_q[1] && line_p_q[0] && !sda_s;
    assign stop_ev = scl_s && line_p_q[1] && !line_p_q[0] && sda_s;

    // Protocol state
    qdci_state_t state_q, state_d;
    logic [3:0] bitcnt_q, bitcnt_d, nbit;
    logic [7:0] sh_q, sh_d, cmd_q, cmd_d, tx_byte;
    logic [15:0] word_q, word_d;
    logic [1:0] byte_q, byte_d, rdch_q, rdch_d;
    logic [PTR_W-1:0] rptr_q, rptr_d;
    logic exec_q, exec_d, oe_q, oe_d, skip_q, skip_d, rdlo_q, rdlo_d;
    logic bit_av, bit_v, take, addr_hit;
    qdci_chan_t [3:0] chan_q, chan_d;
    logic [3:0] mask_q, mask_d;
    logic ref_q, ref_d;

    // Ring read side; a bit is only read once its pointer has crossed
    assign bit_av = rptr_q != wbin;
    assign bit_v = lbuf_q[rptr_q];
    assign take = bit_av && !skip_q && !start_ev && !stop_ev
        && (state_q inside {ST_ADDR, ST_WRITE, ST_READ});
    // Fixed part rules out general call and 10-bit headers
    // The seven address bits are already in the shifter when R/W is taken
    assign addr_hit = sh_q[6:0] == {ADDR_FIXED, pin_s_q[1:0]}; // RULE16 RULE14

    // Byte framing, acknowledge and readback drive; all on the ref clock,
    // which oversamples even fast mode by more than sixty to one
    always_comb begin
        state_d = state_q;
        bitcnt_d = bitcnt_q;
        sh_d = sh_q;
        cmd_d = cmd_q;
        word_d = word_q;
        byte_d = byte_q;
        rptr_d = rptr_q;
        exec_d = 1'b0;
        oe_d = oe_q;
        skip_d = skip_q;
        rdch_d = rdch_q;
        rdlo_d = rdlo_q;
        nbit = (bitcnt_q == ACK_SLOT) ? 4'h0 : bitcnt_q + 4'h1;
        tx_byte = 8'h00;
        if (start_ev) begin
            // The clock fall closing the start lands in the ring: skip it
            state_d = ST_ADDR;
            bitcnt_d = 4'h0;
            byte_d = 2'h0;
            rptr_d = wbin;
            skip_d = 1'b1;
            oe_d = 1'b0;
        end else if (stop_ev) begin
            state_d = ST_IDLE; // RULE20
            rptr_d = wbin;
            oe_d = 1'b0;
        end else if (bit_av) begin
            rptr_d = rptr_q + 1'b1;
            skip_d = 1'b0;
        end
        if (take) begin
            bitcnt_d = nbit; // RULE13
            sh_d = {sh_q[6:0], bit_v}; // RULE1
            case (state_q)
                ST_ADDR: begin
                    if (bitcnt_q == LAST_DATA_SLOT) begin
                        if (!addr_hit) begin
                            state_d = ST_IGNORE; // RULE16
                        end else if (bit_v) begin
                            state_d = ST_READ;
                        end else begin
                            state_d = ST_WRITE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (bitcnt_q == LAST_DATA_SLOT) begin
                        case (byte_q)
                            2'h0: begin
                                cmd_d = sh_d; // RULE2
                                rdlo_d = 1'b0;
                                // Several channels picked: readback starts at A
                                case (sh_d[3:0])
                                    4'h2: rdch_d = 2'h1;
                                    4'h4: rdch_d = 2'h2;
                                    4'h8: rdch_d = 2'h3;
                                    default: rdch_d = 2'h0;
                                endcase
                            end
                            2'h1: word_d[15:8] = sh_d;
                            default: begin
                                word_d[7:0] = sh_d;
                                exec_d = 1'b1; // RULE1 RULE20
                            end
                        endcase
                        byte_d = (byte_q == LAST_BYTE) ? 2'h0 : byte_q + 2'h1;
                    end
                end
                ST_READ: begin
                    if (bitcnt_q == ACK_SLOT) begin
                        if (byte_q != 2'h0 && bit_v) begin
                            state_d = ST_IGNORE; // RULE18
                        end else if (byte_q != 2'h0) begin
                            rdlo_d = !rdlo_q;
                            rdch_d = rdlo_q ? rdch_q + 2'h1 : rdch_q; // RULE18
                        end
                        byte_d = 2'h1;
                    end
                end
                default: ;
            endcase
            // Line level for the low phase that follows
            tx_byte = rdlo_d ? {chan_q[rdch_d].input_code[1:0], 6'h00}
                : chan_q[rdch_d].input_code[9:2];
            oe_d = 1'b0;
            if (nbit == ACK_SLOT && state_q != ST_READ && state_d != ST_IGNORE) begin
                oe_d = 1'b1; // RULE17
            end else if (state_d == ST_READ && nbit != ACK_SLOT) begin
                oe_d = !tx_byte[3'(4'h7 - nbit)]; // RULE18
            end
        end
        if (!resetn) begin
            state_d = ST_IDLE;
            bitcnt_d = 4'h0;
            sh_d = 8'h00;
            cmd_d = 8'h00;
            word_d = 16'h0000;
            byte_d = 2'h0;
            rptr_d = '0;
            exec_d = 1'b0;
            oe_d = 1'b0;
            skip_d = 1'b0;
            rdch_d = 2'h0;
            rdlo_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        state_q <= state_d;
        bitcnt_q <= bitcnt_d;
        sh_q <= sh_d;
        cmd_q <= cmd_d;
        word_q <= word_d;
        byte_q <= byte_d;
        rptr_q <= rptr_d;
        exec_q <= exec_d;
        oe_q <= oe_d;
        skip_q <= skip_d;
        rdch_q <= rdch_d;
        rdlo_q <= rdlo_d;
    end

    // Command execution and the double-buffered channel registers
    logic [CODE_W-1:0] code;
    logic [3:0] op;
    assign code = word_q[CODE_LSB +: CODE_W]; // RULE5 RULE11
    assign op = cmd_q[7:4];

    always_comb begin
        chan_d = chan_q;
        mask_d = mask_q;
        ref_d = ref_q;
        for (int i = 0; i < 4; i++) begin
            if (exec_q && cmd_q[i]) begin // RULE4 RULE7
                case (op) // RULE3
                    CMD_WRITE: chan_d[i].input_code = code; // RULE8
                    CMD_UPDATE: chan_d[i].dac_code = chan_q[i].input_code; // RULE9
                    CMD_WRUPD: begin
                        chan_d[i].input_code = code; // RULE10
                        chan_d[i].dac_code = code;
                    end
                    CMD_POWER: chan_d[i].pwr_mode = word_q[2*i +: 2]; // RULE19
                    default: ; // RULE21
                endcase
            end
            // Load pin low: input register flows through unless masked
            if (!ld_n_s && !mask_q[i] && !(exec_q && op == CMD_WRUPD)) begin
                chan_d[i].dac_code = chan_d[i].input_code; // RULE8
            end
        end
        if (exec_q && op == CMD_LDMASK) begin
            mask_d = word_q[3:0];
        end
        if (exec_q && op == CMD_REFSET) begin
            ref_d = !word_q[REF_OFF_BIT]; // RULE12
        end
        if (!resetn || (exec_q && op == CMD_SWRST)) begin // RULE22
            for (int i = 0; i < 4; i++) begin
                chan_d[i] = {PWR_RESET, CODE_RESET, CODE_RESET}; // RULE15
            end
            mask_d = LDMASK_RESET;
            ref_d = REF_RESET; // RULE12
        end
    end

    always_ff @(posedge ref_clk) begin
        chan_q <= chan_d;
        mask_q <= mask_d;
        ref_q <= ref_d;
    end

    // Open-drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
    assign chan = chan_q;
    assign load_mask = mask_q;
    assign ref_enable = ref_q;

    property p_addr;
        @(posedge ref_clk) disable iff (!resetn)
        take && state_q == ST_ADDR && bitcnt_q == LAST_DATA_SLOT && !addr_hit
        |=> state_q == ST_IGNORE && !sda_oe ##1 !sda_oe;
    endproperty
    a_addr: assert property (p_addr) else $error("foreign address answered"); // RULE16

    property p_ack;
        @(posedge ref_clk) disable iff (!resetn)
        take && state_q == ST_WRITE && bitcnt_q == LAST_DATA_SLOT
        |=> sda_oe && bitcnt_q == ACK_SLOT;
    endproperty
    a_ack: assert property (p_ack) else $error("write byte not acknowledged"); // RULE17

    property p_write;
        @(posedge ref_clk) disable iff (!resetn)
        exec_q && op == CMD_WRITE && cmd_q[0]
        |=> chan_q[0].input_code == $past(code);
    endproperty
    a_write: assert property (p_write) else $error("input register not written"); // RULE8

    property p_update;
        @(posedge ref_clk) disable iff (!resetn)
        exec_q && op == CMD_UPDATE && cmd_q[1]
        |=> chan_q[1].dac_code == $past(chan_q[1].input_code);
    endproperty
    a_update: assert property (p_update) else $error("update did not copy"); // RULE9

    property p_wrupd;
        @(posedge ref_clk) disable iff (!resetn)
        exec_q && op == CMD_WRUPD && cmd_q[3]
        |=> chan_q[3].dac_code == $past(code) && chan_q[3].input_code == $past(code);
    endproperty
    a_wrupd: assert property (p_wrupd) else $error("write and update missed"); // RULE10

    property p_nop;
        @(posedge ref_clk) disable iff (!resetn)
        exec_q && (op == CMD_NOP || op[3])
        |=> $stable(ref_q) && $stable(mask_q) && $stable(chan_q[0].input_code);
    endproperty
    a_nop: assert property (p_nop) else $error("idle command changed state"); // RULE21

    property p_swrst;
        @(posedge ref_clk) disable iff (!resetn)
        exec_q && op == CMD_SWRST
        |=> ref_q && mask_q == LDMASK_RESET && chan_q[2].dac_code == CODE_RESET;
    endproperty
    a_swrst: assert property (p_swrst) else $error("soft reset incomplete"); // RULE22

    property p_exec;
        @(posedge ref_clk) disable iff (!resetn)
        exec_q |-> $past(byte_q) == LAST_BYTE && $past(state_q) == ST_WRITE;
    endproperty
    a_exec: assert property (p_exec) else $error("command ran on a short word"); // RULE20
endmodule

// ### verilog/qdci_pkg.sv
package qdci_pkg;
    // Slave address, upper five bits fixed
    localparam logic [4:0] ADDR_FIXED = 5'h03;
    // Command codes, upper nibble of the command byte
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WRITE = 4'h1;
    localparam logic [3:0] CMD_UPDATE = 4'h2;
    localparam logic [3:0] CMD_WRUPD = 4'h3;
    localparam logic [3:0] CMD_POWER = 4'h4;
    localparam logic [3:0] CMD_LDMASK = 4'h5;
    localparam logic [3:0] CMD_SWRST = 4'h6;
    localparam logic [3:0] CMD_REFSET = 4'h7;
    // Field positions in the 16-bit data word
    localparam int CODE_W = 10;
    localparam int CODE_LSB = 6;
    localparam int REF_OFF_BIT = 0;
    // Bit slots inside one 9-clock byte unit
    localparam logic [3:0] LAST_DATA_SLOT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [1:0] LAST_BYTE = 2'h2;
    // Values after reset
    localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
    localparam logic [1:0] PWR_RESET = 2'h0;
    localparam logic [3:0] LDMASK_RESET = 4'h0;
    localparam logic REF_RESET = 1'b1;
    localparam logic [4:0] PIN_RESET = 5'h1f;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_WRITE = 5'h04,
        ST_READ = 5'h08,
        ST_IGNORE = 5'h10
    } qdci_state_t;

    // One converter channel as seen by the analog side
    typedef struct packed {
        logic [1:0] pwr_mode;
        logic [CODE_W-1:0] dac_code;
        logic [CODE_W-1:0] input_code;
    } qdci_chan_t;
endpackage
